// ===== irq_ctrl_defines.vh
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// ==========================================================================
// source count and layout
// ==========================================================================
`define NUM_SRC 27
`define SRC_IDX_W 5
`define LEVEL_W 2

// per-source control register fields
`define FLD_PEND 7
`define FLD_MASK 6
`define FLD_MACRO 5
`define FLD_CTXSW 4
`define FLD_PRI_HI 1
`define FLD_PRI_LO 0
`define CTRL_RESET 8'h43

// ==========================================================================
// register indices (byte address = 4 * index)
// ==========================================================================
`define CTRL_BASE_IDX 16'hffe0
`define CTRL_LAST_IDX 16'hfffa
`define BULK_BASE_IDX 16'hffac
`define BULK_LAST_IDX 16'hffaf
`define EVT_STATUS_IDX 16'hffb0
`define EVT_MASK_IDX 16'hffb1

// decoded register selector
`define SEL_W 6
`define SEL_BULK0 6'h1b
`define SEL_STATUS 6'h1f
`define SEL_EVMASK 6'h20
`define SEL_NONE 6'h3f

// ==========================================================================
// service modes and event bits
// ==========================================================================
`define MODE_VECTOR 2'h0
`define MODE_CTXSW 2'h1
`define MODE_MACRO 2'h2
`define NUM_EVT 4
`define EVT_VECTOR 0
`define EVT_CTXSW 1
`define EVT_MACRO 2
`define EVT_MACRO_DONE 3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== irq_select.v
`timescale 1ns/100ps
`default_nettype none

`include "irq_ctrl_defines.vh"

// picks the best candidate: lowest level number first, then lowest source index
module irq_select (
    input wire [`NUM_SRC-1:0] cand, // sources eligible this cycle
    input wire [2*`NUM_SRC-1:0] levels, // two level bits per source
    output reg found, // some candidate present
    output reg [`SRC_IDX_W-1:0] src, // winning source
    output reg [`LEVEL_W-1:0] level // winning level
);

    integer i;
    reg [2:0] best;

    always @* begin
        best = 3'h4;
        found = 1'b0;
        src = {`SRC_IDX_W{1'b0}};
        level = {`LEVEL_W{1'b0}};
        // walking downward with <= lets the lowest index win a tie
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (cand[i] && ({1'b0, levels[2*i +: 2]} <= best)) begin
                best = {1'b0, levels[2*i +: 2]};
                found = 1'b1;
                src = i[`SRC_IDX_W-1:0];
                level = levels[2*i +: 2];
            end
        end
    end

endmodule // irq_select

`default_nettype wire

// ===== per_source_interrupt_control.v
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

`include "irq_ctrl_defines.vh"

// What this block does
// - each of the 27 sources has its own two-bit priority in its control register.
// - four priority levels exist; several sources may share one level.
// - priority 00 is highest level 0, 11 is lowest level 3.
// - simultaneous requests at equal level are accepted in fixed default order.
// - context-switch select 1 services the source by register-bank context switching.
// - context-switch 0 and macro-service 0 give an ordinary vectored interrupt.
// - macro-service select 1 routes to macro service, 0 to vectored or context switch.
// - macro service completion clears the macro-service select in hardware.
// - mask flag 1 blocks vectored and macro-service acceptance; 0 allows it.
// - servicing leaves mask unchanged; mask shares storage with the bulk mask bytes.
// - a request sets the pending flag; acceptance clears it in hardware.
// - software reads and writes each control flag individually, pending flag included.
// - reset sets both priority bits and mask, control register reads 0x43.
// - reset clears pending, macro-service and context-switch selects.
// - default order runs from watchdog at 0 to key-return at 26.
// - macro requests bypass priority and global enable; only the mask gates them.
module per_source_interrupt_control (
    input wire aclk, // 125 MHz system clock
    input wire aresetn, // synchronous reset, active low
    // axi4-lite slave
    input wire [31:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [31:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    // peripheral side
    input wire [`NUM_SRC-1:0] irq_req, // one-cycle request pulses
    input wire [`NUM_SRC-1:0] macro_done, // macro counter reached zero
    // cpu acknowledge side
    input wire global_interrupt_enable, // status word enable flag
    input wire take_ready, // cpu can accept a request now
    output wire take_valid, // a request is offered
    output reg accept_q, // one-cycle pulse: request accepted
    output reg [`SRC_IDX_W-1:0] accept_src_q, // accepted source
    output reg [1:0] accept_mode_q, // vector, context switch or macro
    output reg [`LEVEL_W-1:0] accept_level_q, // level of accepted source
    output wire irq // event interrupt, level
);

    // ======================================================================
    // register decode
    // ======================================================================
    function [`SEL_W-1:0] decode;
        input [31:0] addr;
        reg [15:0] idx;
        begin
            idx = addr[17:2];
            decode = `SEL_NONE;
            if (addr[31:18] == 14'h0 && addr[1:0] == 2'h0) begin
                if (idx >= `CTRL_BASE_IDX && idx <= `CTRL_LAST_IDX) begin
                    decode = {1'b0, idx[4:0] - 5'h00};
                end else if (idx >= `BULK_BASE_IDX && idx <= `BULK_LAST_IDX) begin
                    decode = `SEL_BULK0 + {4'h0, idx[1:0]};
                end else if (idx == `EVT_STATUS_IDX) begin
                    decode = `SEL_STATUS;
                end else if (idx == `EVT_MASK_IDX) begin
                    decode = `SEL_EVMASK;
                end
            end
        end
    endfunction

    // ======================================================================
    // write channel
    // ======================================================================
    reg aw_held_q;
    reg w_held_q;
    reg [31:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire [`SEL_W-1:0] wr_sel;
    wire wr_low;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_sel = decode(awaddr_q);
    assign wr_low = wr_fire && wstrb_q[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // arbitration
    // ======================================================================
    wire [`NUM_SRC-1:0] pend;
    wire [`NUM_SRC-1:0] mask;
    wire [`NUM_SRC-1:0] macro_sel;
    wire [`NUM_SRC-1:0] ctx_sel;
    wire [2*`NUM_SRC-1:0] levels;
    wire [`NUM_SRC-1:0] macro_cand;
    wire [`NUM_SRC-1:0] vec_cand;
    wire macro_found;
    wire [`SRC_IDX_W-1:0] macro_src;
    wire vec_found;
    wire [`SRC_IDX_W-1:0] vec_src;
    wire [`LEVEL_W-1:0] vec_level;
    wire [`SRC_IDX_W-1:0] take_src;
    wire grant;

    // macro requests see only the mask, not enable or priority
    assign macro_cand = pend & ~mask & macro_sel;
    // vectored and context-switch requests also need the global enable
    assign vec_cand = pend & ~mask & ~macro_sel & {`NUM_SRC{global_interrupt_enable}};

    irq_select u_macro_select (
        .cand(macro_cand),
        .levels({2*`NUM_SRC{1'b0}}),
        .found(macro_found),
        .src(macro_src),
        .level()
    );

    irq_select u_vec_select (
        .cand(vec_cand),
        .levels(levels),
        .found(vec_found),
        .src(vec_src),
        .level(vec_level)
    );

    assign take_valid = macro_found || vec_found;
    assign grant = take_valid && take_ready;
    assign take_src = macro_found ? macro_src : vec_src;

    always @(posedge aclk) begin
        if (!aresetn) begin
            accept_q <= 1'b0;
            accept_src_q <= {`SRC_IDX_W{1'b0}};
            accept_mode_q <= `MODE_VECTOR;
            accept_level_q <= {`LEVEL_W{1'b0}};
        end else begin
            accept_q <= grant;
            if (grant) begin
                accept_src_q <= take_src;
                if (macro_found) begin
                    accept_mode_q <= `MODE_MACRO;
                    accept_level_q <= levels[2*macro_src +: 2];
                end else begin
                    // context switch select picks bank switching over vectoring
                    accept_mode_q <= ctx_sel[vec_src] ? `MODE_CTXSW : `MODE_VECTOR;
                    accept_level_q <= vec_level;
                end
            end
        end
    end

    // ======================================================================
    // per-source control registers
    // ======================================================================
    genvar g;
    generate
        for (g = 0; g < `NUM_SRC; g = g + 1) begin : gen_src
            reg pend_q;
            reg mask_q;
            reg macro_q;
            reg ctx_q;
            reg pri_hi_q;
            reg pri_lo_q;
            wire wr_ctrl;
            wire wr_bulk;
            wire won;

            assign wr_ctrl = wr_low && (wr_sel == g);
            assign wr_bulk = wr_fire && (wr_sel == `SEL_BULK0 + g / 8)
                && wstrb_q[0];
            assign won = grant && (take_src == g);

            always @(posedge aclk) begin
                if (!aresetn) begin
                    pend_q <= 1'b0;
                    macro_q <= 1'b0;
                    ctx_q <= 1'b0;
                    mask_q <= 1'b1;
                    pri_hi_q <= 1'b1;
                    pri_lo_q <= 1'b1;
                end else begin
                    if (wr_ctrl) begin
                        // bits 3 and 2 have no storage
                        pend_q <= wdata_q[`FLD_PEND];
                        mask_q <= wdata_q[`FLD_MASK];
                        macro_q <= wdata_q[`FLD_MACRO];
                        ctx_q <= wdata_q[`FLD_CTXSW];
                        pri_hi_q <= wdata_q[`FLD_PRI_HI];
                        pri_lo_q <= wdata_q[`FLD_PRI_LO];
                    end
                    // same bit as the bulk mask view
                    if (wr_bulk) begin
                        mask_q <= wdata_q[g % 8];
                    end
                    // acceptance clears pending; a new request in that cycle wins
                    if (won) begin
                        pend_q <= 1'b0;
                    end
                    if (irq_req[g]) begin
                        pend_q <= 1'b1;
                    end
                    // counter end hands the source back to vector or context switch
                    if (macro_done[g]) begin
                        macro_q <= 1'b0;
                    end
                end
            end

            assign pend[g] = pend_q;
            assign mask[g] = mask_q; // servicing never writes it
            assign macro_sel[g] = macro_q;
            assign ctx_sel[g] = ctx_q;
            assign levels[2*g +: 2] = {pri_hi_q, pri_lo_q};
        end
    endgenerate

    // ======================================================================
    // event status and interrupt
    // ======================================================================
    reg [`NUM_EVT-1:0] evt_status_q;
    reg [`NUM_EVT-1:0] evt_mask_q;
    reg [`NUM_EVT-1:0] evt_set;
    wire [`NUM_EVT-1:0] evt_clr;

    always @* begin
        evt_set = {`NUM_EVT{1'b0}};
        evt_set[`EVT_VECTOR] = grant && !macro_found && !ctx_sel[vec_src];
        evt_set[`EVT_CTXSW] = grant && !macro_found && ctx_sel[vec_src];
        evt_set[`EVT_MACRO] = grant && macro_found;
        evt_set[`EVT_MACRO_DONE] = |macro_done;
    end

    assign evt_clr = (wr_low && wr_sel == `SEL_STATUS) ? wdata_q[`NUM_EVT-1:0]
        : {`NUM_EVT{1'b0}};

    always @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_q <= {`NUM_EVT{1'b0}};
            evt_mask_q <= {`NUM_EVT{1'b0}};
        end else begin
            // a new event outranks a clear in the same cycle
            evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
            if (wr_low && wr_sel == `SEL_EVMASK) begin
                evt_mask_q <= wdata_q[`NUM_EVT-1:0];
            end
        end
    end

    assign irq = |(evt_status_q & evt_mask_q);

    // ======================================================================
    // read channel
    // ======================================================================
    wire [`SEL_W-1:0] rd_sel;
    wire [31:0] bulk_word;
    reg [7:0] rd_byte;
    reg [4:0] si;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_sel = decode(s_axi_araddr);
    // unused upper mask positions read as ones
    assign bulk_word = {5'h1f, mask};

    always @* begin
        rd_byte = 8'h00;
        si = rd_sel[4:0];
        if (rd_sel < `NUM_SRC) begin
            // bits 3 and 2 read zero
            rd_byte = {pend[si], mask[si], macro_sel[si], ctx_sel[si], 2'h0,
                levels[2*si +: 2]};
        end else if (rd_sel >= `SEL_BULK0 && rd_sel < `SEL_STATUS) begin
            rd_byte = bulk_word[8*(rd_sel - `SEL_BULK0) +: 8];
        end else if (rd_sel == `SEL_STATUS) begin
            rd_byte = {4'h0, evt_status_q};
        end else if (rd_sel == `SEL_EVMASK) begin
            rd_byte = {4'h0, evt_mask_q};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h0, rd_byte};
                s_axi_rresp <= (rd_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // per_source_interrupt_control

`default_nettype wire

// ===== irq_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module irq_ctrl_checker (
    input wire aclk, // clock
    input wire aresetn, // reset, active low
    input wire s_axi_arready, // read address ready
    input wire s_axi_arvalid, // read address valid
    input wire [31:0] s_axi_rdata, // read data
    input wire s_axi_rvalid, // read valid
    input wire s_axi_rready, // read ready
    input wire [1:0] s_axi_bresp, // write response
    input wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire global_interrupt_enable, // status word enable
    input wire take_ready, // cpu can take
    input wire take_valid, // request offered
    input wire accept_q, // accept pulse
    input wire [`SRC_IDX_W-1:0] accept_src_q, // accepted source
    input wire [1:0] accept_mode_q, // service mode
    input wire irq // event interrupt
);
    // ====================
    // properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    grant_pulse_a: assert property (take_valid && take_ready |=> accept_q)
        else $error("grant without accept pulse");
    accept_cause_a: assert property (accept_q |-> $past(take_valid && take_ready))
        else $error("accept pulse without grant");
    enable_gate_a: assert property (accept_q && accept_mode_q != `MODE_MACRO
        |-> $past(global_interrupt_enable))
        else $error("vectored accept while disabled");
    mode_legal_a: assert property (accept_q |-> accept_mode_q != 2'h3)
        else $error("illegal service mode");
    source_range_a: assert property (accept_q |-> accept_src_q <= 5'h1a)
        else $error("accepted source out of range");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read address taken without answer");
    reset_quiet_a: assert property ($rose(aresetn) |-> !take_valid && !irq && !accept_q)
        else $error("activity right after reset");
endmodule // irq_ctrl_checker

bind per_source_interrupt_control irq_ctrl_checker u_irq_ctrl_checker (.aclk, .aresetn,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .global_interrupt_enable, .take_ready, .take_valid, .accept_q,
    .accept_src_q, .accept_mode_q, .irq, .s_axi_arvalid);
`default_nettype wire

// ===== cpu_ack_model.sv
`timescale 1ns/100ps
`default_nettype none
// cpu acknowledge side: prompt, stalled, or every other cycle
module cpu_ack_model (
    input wire aclk, // clock
    input wire aresetn, // reset, active low
    input wire hold, // bench stalls the cpu
    input wire slow, // take only every other cycle
    output logic take_ready // cpu takes a request
);
    logic odd_q;
    always @(posedge aclk) begin
        odd_q <= aresetn ? !odd_q : 1'b0;
        take_ready <= aresetn && !hold && (!slow || odd_q);
    end
endmodule // cpu_ack_model
`default_nettype wire

// ===== tb_per_source_interrupt_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module tb_per_source_interrupt_control;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [26:0] irq_req = 27'h0, macro_done = 27'h0;
    logic global_interrupt_enable = 1'b0, hold = 1'b1, slow = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, accept_mode_q, accept_level_q;
    wire [31:0] s_axi_rdata;
    wire [4:0] accept_src_q;
    wire take_ready, take_valid, accept_q, irq;
    int bad_count = 0, tests_run = 0;
    logic [8:0] seen[$], ex[$];
    logic [31:0] rd_q;
    logic [1:0] rs_q;
    localparam logic [31:0] CTRL = 32'h3ff80, BULK = 32'h3feb0;
    localparam logic [31:0] EST = 32'h3fec0, EMSK = 32'h3fec4;
    localparam logic [1:0] OK = `RESP_OKAY;

    always #4 aclk = ~aclk;

    per_source_interrupt_control u_per_source_interrupt_control (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_req, .macro_done, .global_interrupt_enable,
        .take_ready, .take_valid, .accept_q, .accept_src_q, .accept_mode_q,
        .accept_level_q, .irq);
    cpu_ack_model u_cpu_ack_model (.aclk, .aresetn, .hold, .slow, .take_ready);

    always @(posedge aclk) if (accept_q === 1'b1)
        seen.push_back({accept_level_q, accept_mode_q, accept_src_q});

    // ====================
    // bus tasks
    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run++;
            if (got !== exp) begin
                bad_count++;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task automatic wr(input [31:0] a, input [7:0] d, input [1:0] er);
        logic aw, w;
        begin
            aw = 1'b0;
            w = 1'b0;
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            while (!(aw && w)) begin
                @(posedge aclk);
                if (s_axi_awvalid && s_axi_awready) begin
                    aw = 1'b1;
                    s_axi_awvalid <= 1'b0;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w = 1'b1;
                    s_axi_wvalid <= 1'b0;
                end
            end
            // accept the response late, so that bvalid is seen waiting once
            repeat (2) @(posedge aclk);
            s_axi_bready <= 1'b1;
            do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, er);
            @(posedge aclk);
        end
    endtask
    task automatic rd(input [31:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            do @(posedge aclk); while (s_axi_arready !== 1'b1);
            s_axi_arvalid <= 1'b0;
            // one cycle late, so that rvalid is seen waiting once
            @(posedge aclk);
            s_axi_rready <= 1'b1;
            do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
            s_axi_rready <= 1'b0;
            rd_q = s_axi_rdata;
            rs_q = s_axi_rresp;
            @(posedge aclk);
        end
    endtask
    task automatic rdchk(input [31:0] a, input [7:0] e, input [1:0] er);
        begin
            rd(a);
            chk(rd_q, {24'h0, e});
            chk(rs_q, er);
        end
    endtask
    // pulse requests with the cpu stalled, then let it take them all
    task automatic burst(input [26:0] m);
        int n;
        begin
            irq_req <= m;
            @(posedge aclk);
            irq_req <= 27'h0;
            repeat (2) @(posedge aclk);
            seen.delete();
            hold <= 1'b0;
            for (n = 0; n < 40 && (n < 3 || take_valid !== 1'b0); n++) @(posedge aclk);
            repeat (2) @(posedge aclk);
            hold <= 1'b1;
            repeat (3) @(posedge aclk);
            chk(seen.size(), ex.size());
            foreach (ex[i]) chk(seen[i], ex[i]);
            ex.delete();
            $display("TB: burst test done, %0d accepts", seen.size());
        end
    endtask
    task automatic report_and_stop();
        begin
            $display("TB: %0d checks, %0d mismatches", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // ====================
    // tests
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(irq, 1'b0);
        for (int i = 0; i < 27; i++) rdchk(CTRL + 4 * i, 8'h43, OK);
        rdchk(BULK + 32'hc, 8'hff, OK);
        rdchk(32'h0, 8'h00, `RESP_SLVERR);
        wr(32'h4, 8'h01, `RESP_SLVERR);
        wr(EMSK, 8'h0f, OK);
        wr(CTRL, 8'hff, OK);
        rdchk(CTRL, 8'hf3, OK);
        wr(BULK, 8'hfe, OK);
        rdchk(CTRL, 8'hb3, OK);
        ex.push_back({2'h3, `MODE_MACRO, 5'h00});
        burst(27'h0);
        rdchk(CTRL, 8'h33, OK);
        macro_done <= 27'h1;
        @(posedge aclk);
        macro_done <= 27'h0;
        @(posedge aclk);
        rdchk(CTRL, 8'h13, OK);
        $display("TB: register test done");
        // equal and differing levels, cpu answering slowly
        global_interrupt_enable <= 1'b1;
        slow <= 1'b1;
        wr(CTRL + 32'h08, 8'h02, OK);
        wr(CTRL + 32'h0c, 8'h01, OK);
        wr(CTRL + 32'h14, 8'h00, OK);
        wr(CTRL + 32'h1c, 8'h02, OK);
        ex.push_back({2'h0, `MODE_VECTOR, 5'h05});
        ex.push_back({2'h1, `MODE_VECTOR, 5'h03});
        ex.push_back({2'h2, `MODE_VECTOR, 5'h02});
        ex.push_back({2'h2, `MODE_VECTOR, 5'h07});
        burst(27'h0ac);
        slow <= 1'b0;
        wr(CTRL + 32'h24, 8'h10, OK);
        wr(CTRL + 32'h68, 8'h23, OK);
        global_interrupt_enable <= 1'b0;
        ex.push_back({2'h3, `MODE_MACRO, 5'h1a});
        burst(27'h4000200);
        global_interrupt_enable <= 1'b1;
        ex.push_back({2'h0, `MODE_CTXSW, 5'h09});
        burst(27'h0);
        wr(CTRL + 32'h10, 8'h40, OK);
        burst(27'h10);
        rdchk(CTRL + 32'h10, 8'hc0, OK);
        // event status and interrupt output
        chk(irq, 1'b1);
        rdchk(EST, 8'h0f, OK);
        wr(EMSK, 8'h00, OK);
        chk(irq, 1'b0);
        wr(EST, 8'h0f, OK);
        rdchk(EST, 8'h00, OK);
        wr(EMSK, 8'h0f, OK);
        chk(irq, 1'b0);
        $display("TB: event test done");
        report_and_stop();
    end
endmodule // tb_per_source_interrupt_control
`default_nettype wire
